// ---- rtl/scl_map.svh ----
`ifndef SCL_MAP_SVH
`define SCL_MAP_SVH
`define SCL_DATA_BITS     8
`define SCL_STOP_BITS     1
`define SCL_CLK_HZ        125000000
`define SCL_BAUD_MIN      9600
`define SCL_BAUD_MAX      115200
`define SCL_CODE_REQUEST  8'haa
`define SCL_CODE_READY    8'hcc
`define SCL_CODE_TERM     8'h0a
`endif

// ---- rtl/scl_pkg.sv ----
package scl_pkg;
    typedef enum logic [1:0] {
        SCL_IDLE,
        SCL_START,
        SCL_DATA,
        SCL_STOP
    } scl_bit_state_t;
    typedef enum logic [1:0] {
        SCL_WAIT_REQ,
        SCL_SEND_READY,
        SCL_IN_CMD
    } scl_link_state_t;
endpackage

// ---- rtl/scl_link.sv ----
`timescale 1ns/10ps
`include "scl_map.svh"
module scl_link #(
    parameter int DIV_W = 16
) (
    input  wire logic             core_clk_in,
    input  wire logic             rst_in,
    input  wire logic             ce_in,
    input  wire logic [DIV_W-1:0] baud_div_in,
    input  wire logic             rxd_in,
    output logic                  txd_out,
    output logic [7:0]            cmd_data_out,
    output logic                  cmd_valid_out,
    output logic                  cmd_end_out,
    output logic                  frame_err_out,
    input  wire logic [7:0]       resp_data_in,
    input  wire logic             resp_valid_in,
    output logic                  resp_ready_out
);
    // ****************************************
    // baud divider bounds
    // ****************************************
    localparam int DIV_MAX = `SCL_CLK_HZ / `SCL_BAUD_MIN;
    localparam int DIV_MIN = `SCL_CLK_HZ / `SCL_BAUD_MAX;
    localparam logic [DIV_W-1:0] DIV_LO = DIV_W'(DIV_MIN);
    localparam logic [DIV_W-1:0] DIV_HI = DIV_W'(DIV_MAX);

    function automatic logic [DIV_W-1:0] clamp_div(input logic [DIV_W-1:0] d);
        if (d < DIV_LO) begin
            return DIV_LO;
        end else if (d > DIV_HI) begin
            return DIV_HI;
        end
        return d;
    endfunction

    wire logic [DIV_W-1:0] div_w = clamp_div(baud_div_in);
    wire logic [DIV_W-1:0] half_w = {1'b0, div_w[DIV_W-1:1]};

    // ****************************************
    // receiver
    // ****************************************
    scl_pkg::scl_bit_state_t rx_st_reg;
    logic [DIV_W-1:0]        rx_cnt_reg;
    logic [2:0]              rx_bit_reg;
    logic [7:0]              rx_sh_reg;
    logic                    rx_done_reg;
    logic                    rx_err_reg;
    wire logic               rx_tick = (rx_cnt_reg == '0);

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            rx_st_reg   <= scl_pkg::SCL_IDLE;
            rx_cnt_reg  <= '0;
            rx_bit_reg  <= '0;
            rx_sh_reg   <= '0;
            rx_done_reg <= 1'b0;
            rx_err_reg  <= 1'b0;
        end else if (ce_in) begin
            rx_done_reg <= 1'b0;
            rx_err_reg  <= 1'b0;
            if (!rx_tick) begin
                rx_cnt_reg <= rx_cnt_reg - 1'b1;
            end
            case (rx_st_reg)
                scl_pkg::SCL_IDLE: begin
                    if (!rxd_in) begin
                        rx_st_reg  <= scl_pkg::SCL_START;
                        rx_cnt_reg <= half_w;
                    end
                end
                scl_pkg::SCL_START: begin
                    if (rx_tick) begin
                        rx_st_reg  <= rxd_in ? scl_pkg::SCL_IDLE : scl_pkg::SCL_DATA;
                        rx_cnt_reg <= div_w;
                        rx_bit_reg <= '0;
                    end
                end
                scl_pkg::SCL_DATA: begin
                    if (rx_tick) begin
                        rx_sh_reg  <= {rxd_in, rx_sh_reg[7:1]};
                        rx_cnt_reg <= div_w;
                        rx_bit_reg <= rx_bit_reg + 1'b1;
                        if (rx_bit_reg == 3'(`SCL_DATA_BITS - 1)) begin
                            rx_st_reg <= scl_pkg::SCL_STOP;
                        end
                    end
                end
                scl_pkg::SCL_STOP: begin
                    if (rx_tick) begin
                        rx_st_reg   <= scl_pkg::SCL_IDLE;
                        rx_done_reg <= rxd_in;
                        rx_err_reg  <= !rxd_in;
                    end
                end
                default: rx_st_reg <= scl_pkg::SCL_IDLE;
            endcase
        end
    end

    // ****************************************
    // command handshake
    // ****************************************
    scl_pkg::scl_link_state_t lk_st_reg;
    logic                     ready_req_reg;
    wire logic is_req  = rx_done_reg && (rx_sh_reg == `SCL_CODE_REQUEST);
    wire logic is_term = rx_done_reg && (rx_sh_reg == `SCL_CODE_TERM);
    wire logic ready_taken;

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            lk_st_reg     <= scl_pkg::SCL_WAIT_REQ;
            ready_req_reg <= 1'b0;
            cmd_data_out  <= '0;
            cmd_valid_out <= 1'b0;
            cmd_end_out   <= 1'b0;
            frame_err_out <= 1'b0;
        end else if (ce_in) begin
            cmd_valid_out <= 1'b0;
            cmd_end_out   <= 1'b0;
            frame_err_out <= rx_err_reg;
            if (ready_taken) begin
                ready_req_reg <= 1'b0;
            end
            case (lk_st_reg)
                scl_pkg::SCL_WAIT_REQ: begin
                    if (is_req) begin
                        lk_st_reg     <= scl_pkg::SCL_SEND_READY;
                        ready_req_reg <= 1'b1;
                    end
                end
                scl_pkg::SCL_SEND_READY: begin
                    if (ready_taken) begin
                        lk_st_reg <= scl_pkg::SCL_IN_CMD;
                    end
                end
                scl_pkg::SCL_IN_CMD: begin
                    if (rx_done_reg) begin
                        cmd_data_out <= rx_sh_reg;
                        if (is_term) begin
                            cmd_end_out <= 1'b1;
                            lk_st_reg   <= scl_pkg::SCL_WAIT_REQ;
                        end else begin
                            cmd_valid_out <= 1'b1;
                        end
                    end
                end
                default: lk_st_reg <= scl_pkg::SCL_WAIT_REQ;
            endcase
        end
    end

    // ****************************************
    // transmitter
    // ****************************************
    scl_pkg::scl_bit_state_t tx_st_reg;
    logic [DIV_W-1:0]        tx_cnt_reg;
    logic [2:0]              tx_bit_reg;
    logic [7:0]              tx_sh_reg;
    wire logic tx_tick  = (tx_cnt_reg == '0);
    wire logic tx_idle  = (tx_st_reg == scl_pkg::SCL_IDLE);
    assign ready_taken  = tx_idle && ready_req_reg && ce_in;
    wire logic resp_go  = tx_idle && !ready_req_reg && resp_valid_in && ce_in;

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            tx_st_reg      <= scl_pkg::SCL_IDLE;
            tx_cnt_reg     <= '0;
            tx_bit_reg     <= '0;
            tx_sh_reg      <= '0;
            txd_out        <= 1'b1;
            resp_ready_out <= 1'b0;
        end else if (ce_in) begin
            resp_ready_out <= 1'b0;
            if (!tx_tick) begin
                tx_cnt_reg <= tx_cnt_reg - 1'b1;
            end
            case (tx_st_reg)
                scl_pkg::SCL_IDLE: begin
                    txd_out <= 1'b1;
                    if (ready_taken || resp_go) begin
                        tx_sh_reg      <= ready_taken ? `SCL_CODE_READY : resp_data_in;
                        resp_ready_out <= resp_go;
                        tx_st_reg      <= scl_pkg::SCL_START;
                        tx_cnt_reg     <= div_w;
                        txd_out        <= 1'b0;
                    end
                end
                scl_pkg::SCL_START: begin
                    if (tx_tick) begin
                        tx_st_reg  <= scl_pkg::SCL_DATA;
                        tx_cnt_reg <= div_w;
                        tx_bit_reg <= '0;
                        txd_out    <= tx_sh_reg[0];
                    end
                end
                scl_pkg::SCL_DATA: begin
                    if (tx_tick) begin
                        tx_cnt_reg <= div_w;
                        tx_bit_reg <= tx_bit_reg + 1'b1;
                        tx_sh_reg  <= {1'b1, tx_sh_reg[7:1]};
                        if (tx_bit_reg == 3'(`SCL_DATA_BITS - 1)) begin
                            tx_st_reg <= scl_pkg::SCL_STOP;
                            txd_out   <= 1'b1;
                        end else begin
                            txd_out <= tx_sh_reg[1];
                        end
                    end
                end
                scl_pkg::SCL_STOP: begin
                    if (tx_tick) begin
                        tx_st_reg <= scl_pkg::SCL_IDLE;
                    end
                end
                default: tx_st_reg <= scl_pkg::SCL_IDLE;
            endcase
        end
    end

    // ****************************************
    // checks
    // ****************************************
    AST_READY_AFTER_REQ: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (lk_st_reg == scl_pkg::SCL_WAIT_REQ && is_req && ce_in) |=> ready_req_reg)
        else $error("ready code not queued after request");
    AST_END_ON_TERM: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (lk_st_reg == scl_pkg::SCL_IN_CMD && is_term && ce_in) |=> cmd_end_out && !cmd_valid_out)
        else $error("terminator not reported as end");
    AST_NO_CMD_BEFORE_REQ: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (lk_st_reg != scl_pkg::SCL_IN_CMD) |=> !cmd_valid_out)
        else $error("command byte outside command phase");
    AST_START_LOW: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (tx_st_reg == scl_pkg::SCL_START) |-> !txd_out)
        else $error("start bit not low");
    AST_STOP_HIGH: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (tx_st_reg == scl_pkg::SCL_STOP) |-> txd_out)
        else $error("stop bit not high");
    AST_RESP_DIRECT: assert property (@(posedge core_clk_in) disable iff (rst_in)
        resp_go |=> resp_ready_out && tx_st_reg == scl_pkg::SCL_START)
        else $error("response not sent directly");
    AST_DIV_RANGE: assert property (@(posedge core_clk_in) disable iff (rst_in)
        tx_cnt_reg <= DIV_HI && rx_cnt_reg <= DIV_HI)
        else $error("bit counter out of range");
    AST_READY_CODE: assert property (@(posedge core_clk_in) disable iff (rst_in)
        ready_taken |=> tx_sh_reg == `SCL_CODE_READY)
        else $error("wrong ready code");
    AST_RX_FRAME: assert property (@(posedge core_clk_in) disable iff (rst_in)
        rx_done_reg && $past(ce_in) |-> $past(rx_st_reg) == scl_pkg::SCL_STOP)
        else $error("byte done outside stop bit");
endmodule

// ---- tb/scl_host_model.sv ----
`timescale 1ns/10ps
// ****************************************
// host side of the serial link
// ****************************************
module scl_host_model (
    input  wire logic        clk_in,
    input  wire logic [15:0] div_in,
    input  wire logic        txd_in,
    output logic             rxd_out
);
    logic [7:0] rx_byte;
    int         rx_count;
    int         start_count;
    initial begin
        rxd_out     = 1'b1;
        rx_count    = 0;
        start_count = 0;
    end
    // one character, start, lsb first, stop as given, no parity
    task automatic send_frame(input logic [7:0] b, input logic stop);
        logic [9:0] f;
        f = {stop, b, 1'b0};
        @(posedge clk_in);
        #1;
        for (int i = 0; i < 10; i++) begin
            rxd_out = f[i];
            repeat (div_in) @(posedge clk_in);
            #1;
        end
        if (!stop) begin
            rxd_out = 1'b1;
            repeat (div_in) @(posedge clk_in);
            #1;
        end
    endtask
    task automatic send_byte(input logic [7:0] b);
        send_frame(b, 1'b1);
    endtask
    // always ready to take characters
    always begin
        @(negedge txd_in);
        start_count++;
        repeat (div_in / 2) @(posedge clk_in);
        for (int i = 0; i < 8; i++) begin
            repeat (div_in) @(posedge clk_in);
            rx_byte[i] = txd_in;
        end
        repeat (div_in) @(posedge clk_in);
        if (txd_in === 1'b1) rx_count++;
    end
endmodule

// ---- tb/scl_link_tb_top.sv ----
`timescale 1ns/10ps
// ****************************************
// link testbench
// ****************************************
module scl_link_tb_top;
    localparam logic [15:0] DIV = 16'h043d;
    logic [15:0] div;
    logic       core_clk_in, rst_in, ce_in, rxd, txd;
    logic [7:0] cmd_data, resp_data, last_cmd;
    logic       cmd_valid, cmd_end, frame_err, resp_valid, resp_ready;
    int         err_count, num_checks, n_valid, n_end, n_ready, cycles, n_ferr;

    scl_link u_dut (.core_clk_in(core_clk_in), .rst_in(rst_in), .ce_in(ce_in),
        .baud_div_in(div), .rxd_in(rxd), .txd_out(txd), .cmd_data_out(cmd_data),
        .cmd_valid_out(cmd_valid), .cmd_end_out(cmd_end), .frame_err_out(frame_err),
        .resp_data_in(resp_data), .resp_valid_in(resp_valid), .resp_ready_out(resp_ready));
    scl_host_model u_host (.clk_in(core_clk_in), .div_in(div), .txd_in(txd), .rxd_out(rxd));

    initial begin
        core_clk_in = 1'b0;
        forever #4 core_clk_in = ~core_clk_in;
    end
    always @(posedge core_clk_in) begin
        cycles++;
        if (cmd_valid === 1'b1) begin
            n_valid++;
            last_cmd = cmd_data;
        end
        if (cmd_end === 1'b1) n_end++;
        if (resp_ready === 1'b1) n_ready++;
        if (frame_err === 1'b1) n_ferr++;
        if (cycles == 95000) begin
            err_count++;
            report_and_stop();
        end
    end

    task automatic check8(input logic [7:0] seen, input logic [7:0] exp, input string msg);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %0t %s", $time, msg);
        end
    endtask
    task automatic wait_rx(input int n);
        int k;
        k = 0;
        while (u_host.rx_count == n && k < 20000) begin
            @(posedge core_clk_in);
            k++;
        end
        if (k >= 20000) begin
            err_count++;
            $display("CHECK FAILED %0t wait limit", $time);
        end
    endtask
    task automatic report_and_stop();
        if (err_count == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic test_handshake();
        check8({7'h00, txd}, 8'h01, "idle line");
        u_host.send_byte(8'h55);
        repeat (20) @(posedge core_clk_in);
        check8(8'(u_host.rx_count), 8'h00, "answer to non request");
        check8(8'(u_host.start_count), 8'h00, "start bit after non request");
        check8(8'(n_valid), 8'h00, "byte before request");
        u_host.send_byte(8'haa);
        wait_rx(0);
        check8(u_host.rx_byte, 8'hcc, "ready code");
        check8(8'(u_host.start_count), 8'h01, "one ready character");
        u_host.send_byte(8'h31);
        repeat (20) @(posedge core_clk_in);
        check8(8'(n_valid), 8'h01, "command byte count");
        check8(last_cmd, 8'h31, "command byte value");
        u_host.send_byte(8'h0a);
        repeat (20) @(posedge core_clk_in);
        check8(8'(n_end), 8'h01, "end of command");
        check8(8'(n_valid), 8'h01, "terminator passed as data");
        check8(8'(n_ferr), 8'h00, "frame error");
    endtask
    task automatic test_frame_err();
        u_host.send_frame(8'haa, 1'b0);
        repeat (20) @(posedge core_clk_in);
        check8(8'(n_ferr), 8'h01, "low stop bit flagged");
        check8(8'(u_host.start_count), 8'h01, "broken request answered");
        check8(8'(n_valid), 8'h01, "broken byte passed on");
    endtask
    task automatic test_response();
        int k;
        k = 0;
        @(posedge core_clk_in);
        #1;
        div        = 16'h0600;
        resp_data  = 8'h5a;
        resp_valid = 1'b1;
        while (resp_ready !== 1'b1 && k < 100) begin
            @(posedge core_clk_in);
            k++;
        end
        if (k >= 100) begin
            err_count++;
            $display("CHECK FAILED %0t response wait limit", $time);
        end
        #1;
        resp_valid = 1'b0;
        wait_rx(1);
        check8(8'(n_ready), 8'h01, "response taken");
        check8(u_host.rx_byte, 8'h5a, "response byte");
        check8(8'(u_host.start_count), 8'h02, "one response character");
    endtask

    initial begin
        err_count  = 0;
        num_checks = 0;
        n_valid    = 0;
        n_end      = 0;
        n_ready    = 0;
        cycles     = 0;
        n_ferr     = 0;
        div        = DIV;
        rst_in     = 1'b1;
        ce_in      = 1'b1;
        resp_data  = 8'h00;
        resp_valid = 1'b0;
        repeat (3) @(posedge core_clk_in);
        #1;
        rst_in = 1'b0;
        test_handshake();
        test_frame_err();
        test_response();
        report_and_stop();
    end
endmodule
